/* File: core/tsc_consts.svh */
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

// register byte offsets
`define TSC_OFF_CMD      8'h00
`define TSC_OFF_SEL      8'h04
`define TSC_OFF_DBASE    8'h08
`define TSC_OFF_DLIMIT   8'h0C
`define TSC_OFF_DATTR    8'h10
`define TSC_OFF_MCR      8'h14
`define TSC_OFF_PDBR     8'h18
`define TSC_OFF_FLAGS    8'h1C
`define TSC_OFF_TRSEL    8'h20
`define TSC_OFF_TRBASE   8'h24
`define TSC_OFF_TRLIM    8'h28
`define TSC_OFF_RESULT   8'h2C
`define TSC_OFF_STATUS   8'h30

// field positions
`define TSC_FLAG_NT_BIT  14
`define TSC_FLAG_VM_BIT  17
`define TSC_MCR_PE_BIT   0
`define TSC_MCR_MP_BIT   1
`define TSC_MCR_TS_BIT   3
`define TSC_ATTR_T_BIT   8
`define TSC_ATTR_VM_BIT  9
`define TSC_ATTR_NT_BIT  10
`define TSC_PDBR_LSB     12

// descriptor types
`define TSC_TYPE_TSS32   4'h9
`define TSC_TYPE_TSS32B  4'hB
`define TSC_TYPE_TSS16   4'h1
`define TSC_TYPE_TSS16B  4'h3
`define TSC_TYPE_GATE    4'h5

// limits that must be exceeded
`define TSC_MIN_LIM32    32'h0000_0064
`define TSC_MIN_LIM16    32'h0000_002B

// exception vectors
`define TSC_VEC_GP       8'h0D
`define TSC_VEC_NOCOP    8'h07
`define TSC_VEC_DEBUG    8'h01
`define TSC_VEC_BADTSS   8'h0A

// reset values
`define TSC_RST_WORD     32'h0000_0000

`endif

/* File: core/tsc_pkg.sv */
package tsc_pkg;

    typedef enum {
        ST_IDLE,
        ST_CHECK,
        ST_SAVE,
        ST_LOAD,
        ST_DONE
    } tsc_state_type;

    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_JMP  = 4'h1,
        CMD_CALL = 4'h2,
        CMD_INT  = 4'h3,
        CMD_INTERRUPT_RETURN = 4'h4,
        CMD_FLAG_POP_INSTR = 4'h5,
        CMD_ESC  = 4'h6,
        CMD_WAIT = 4'h7
    } tsc_cmd_type;

endpackage

/* File: core/tsc_top.sv */
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_consts.svh"

module tsc_top
    import tsc_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             switch_save_o,
    output logic             switch_load_o,
    output logic             tlb_flush_o,
    output logic             exception_o,
    output logic      [7:0]  exception_vec_o,
    output logic             protected_mode_o,
    output logic             virtual_mode_o
);

    tsc_state_type state_r;
    tsc_state_type state_nxt;
    tsc_cmd_type   cmd_r;
    logic          flag_pop_instr_nt_r;
    logic [15:0]   sel_r;
    logic [31:0]   dbase_r;
    logic [31:0]   dlimit_r;
    logic [31:0]   dattr_r;
    logic          pe_r;
    logic          mp_r;
    logic          ts_r;
    logic [31:12]  pdbr_r;
    logic          nt_r;
    logic          nt_saved_r;
    logic          vm_r;
    logic [15:0]   tr_sel_r;
    logic [31:0]   tr_base_r;
    logic [31:0]   tr_limit_r;
    logic [7:0]    exc_vec_r;
    logic          exc_valid_r;
    logic [3:0]    busy_type_r;
    logic [15:0]   link_sel_r;
    logic [7:0]    switch_cnt_r;

    // bus decode
    wire        req      = avs_read_i | avs_write_i;
    wire        is_cmd   = avs_write_i & (avs_address_i == `TSC_OFF_CMD);
    wire        take     = req & avs_waitrequest_o;
    wire        start    = is_cmd & take & (state_r == ST_IDLE);
    wire        wr_take  = avs_write_i & avs_waitrequest_o & !is_cmd;
    wire        wait_nxt = !((take & !is_cmd) | (state_r == ST_DONE));
    wire [31:0] be_mask  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                            {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    wire        wr_sel   = wr_take & (avs_address_i == `TSC_OFF_SEL);
    wire        wr_dbase = wr_take & (avs_address_i == `TSC_OFF_DBASE);
    wire        wr_dlim  = wr_take & (avs_address_i == `TSC_OFF_DLIMIT);
    wire        wr_dattr = wr_take & (avs_address_i == `TSC_OFF_DATTR);
    wire        wr_mcr   = wr_take & (avs_address_i == `TSC_OFF_MCR);
    wire        wr_pdbr  = wr_take & (avs_address_i == `TSC_OFF_PDBR);

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [31:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    wire [31:0] sel_w   = merge({16'h0000, sel_r}, avs_writedata_i, be_mask);
    wire [31:0] mcr_old = {28'h000_0000, ts_r, 1'b0, mp_r, pe_r};
    wire [31:0] mcr_w   = merge(mcr_old, avs_writedata_i, be_mask);
    wire [31:0] pdbr_w  = merge({pdbr_r, 12'h000}, avs_writedata_i, be_mask);

    // descriptor and command decisions
    wire [3:0]  named_type  = dattr_r[3:0];
    wire        named_gate  = named_type == `TSC_TYPE_GATE;
    wire        named_tss   = (named_type == `TSC_TYPE_TSS32) | (named_type == `TSC_TYPE_TSS32B)
                            | (named_type == `TSC_TYPE_TSS16) | (named_type == `TSC_TYPE_TSS16B);
    wire [3:0]  tgt_type    = named_gate ? dattr_r[7:4] : named_type;
    wire        tgt_busy    = (tgt_type == `TSC_TYPE_TSS32B) | (tgt_type == `TSC_TYPE_TSS16B);
    wire        tgt_32      = (tgt_type == `TSC_TYPE_TSS32) | (tgt_type == `TSC_TYPE_TSS32B);
    wire        lim_ok      = tgt_32 ? (dlimit_r > `TSC_MIN_LIM32)
                                     : (dlimit_r > `TSC_MIN_LIM16);
    wire        is_jc       = (cmd_r == CMD_JMP) | (cmd_r == CMD_CALL);
    wire        nests       = (cmd_r == CMD_CALL) | (cmd_r == CMD_INT);
    wire        jc_switch   = is_jc & (named_gate | named_tss);
    wire        int_switch  = (cmd_r == CMD_INT) & named_gate;
    wire        interrupt_return_switch = (cmd_r == CMD_INTERRUPT_RETURN) & nt_r;
    wire        fwd_switch  = jc_switch | int_switch;
    wire        any_switch  = fwd_switch | interrupt_return_switch;
    wire        fault_busy  = fwd_switch & tgt_busy;
    wire        fault_lim   = any_switch & !lim_ok;
    wire        trap_esc    = (cmd_r == CMD_ESC) & ts_r;
    wire        trap_wait   = (cmd_r == CMD_WAIT) & ts_r & mp_r;
    wire        chk_fault   = fault_busy | fault_lim | trap_esc | trap_wait;
    wire [7:0]  chk_vec     = fault_busy ? `TSC_VEC_GP
                            : fault_lim  ? `TSC_VEC_BADTSS : `TSC_VEC_NOCOP;
    wire [15:0] tgt_sel     = interrupt_return_switch ? dattr_r[31:16] : sel_r;
    wire [3:0]  busy_type   = tgt_32 ? `TSC_TYPE_TSS32B : `TSC_TYPE_TSS16B;
    wire        in_check    = state_r == ST_CHECK;
    wire        in_load     = state_r == ST_LOAD;
    wire        flush_now   = wr_pdbr | (in_load & !ts_r);

    // readback
    wire [31:0] flags_rd  = {14'h0000, vm_r, 2'b00, nt_r, 14'h0000};
    wire [31:0] result_rd = {link_sel_r, busy_type_r, 3'b000, exc_valid_r, exc_vec_r};
    wire [31:0] status_rd = {16'h0000, switch_cnt_r, 5'b00000, ts_r, vm_r, pe_r};
    wire [31:0] rd_mux =
        (avs_address_i == `TSC_OFF_SEL)    ? {16'h0000, sel_r} :
        (avs_address_i == `TSC_OFF_DBASE)  ? dbase_r :
        (avs_address_i == `TSC_OFF_DLIMIT) ? dlimit_r :
        (avs_address_i == `TSC_OFF_DATTR)  ? dattr_r :
        (avs_address_i == `TSC_OFF_MCR)    ? mcr_old :
        (avs_address_i == `TSC_OFF_PDBR)   ? {pdbr_r, 12'h000} :
        (avs_address_i == `TSC_OFF_FLAGS)  ? flags_rd :
        (avs_address_i == `TSC_OFF_TRSEL)  ? {16'h0000, tr_sel_r} :
        (avs_address_i == `TSC_OFF_TRBASE) ? tr_base_r :
        (avs_address_i == `TSC_OFF_TRLIM)  ? tr_limit_r :
        (avs_address_i == `TSC_OFF_RESULT) ? result_rd :
        (avs_address_i == `TSC_OFF_STATUS) ? status_rd : `TSC_RST_WORD;

    // sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:  state_nxt = start ? ST_CHECK : ST_IDLE;
            ST_CHECK: state_nxt = (any_switch & !chk_fault) ? ST_SAVE : ST_DONE;
            ST_SAVE:  state_nxt = ST_LOAD;
            ST_LOAD:  state_nxt = ST_DONE;
            ST_DONE:  state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            state_r           <= ST_IDLE;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= `TSC_RST_WORD;
        end else begin
            state_r           <= state_nxt;
            avs_waitrequest_o <= wait_nxt;
            if (avs_read_i && take) begin
                avs_readdata_o <= rd_mux;
            end
        end
    end

    // software-written descriptor staging
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            cmd_r     <= CMD_NONE;
            flag_pop_instr_nt_r <= 1'b0;
            sel_r     <= 16'h0000;
            dbase_r   <= `TSC_RST_WORD;
            dlimit_r  <= `TSC_RST_WORD;
            dattr_r   <= `TSC_RST_WORD;
            pdbr_r    <= 20'h0_0000;
        end else begin
            if (start) begin
                cmd_r     <= tsc_cmd_type'(avs_writedata_i[3:0]);
                flag_pop_instr_nt_r <= avs_writedata_i[`TSC_FLAG_NT_BIT];
            end
            if (wr_sel) sel_r <= sel_w[15:0];
            if (wr_dbase) dbase_r <= merge(dbase_r, avs_writedata_i, be_mask);
            if (wr_dlim) dlimit_r <= merge(dlimit_r, avs_writedata_i, be_mask);
            if (wr_dattr) dattr_r <= merge(dattr_r, avs_writedata_i, be_mask);
            if (wr_pdbr) pdbr_r <= pdbr_w[31:12];
        end
    end

    // machine control bits
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            pe_r <= 1'b0;
            mp_r <= 1'b0;
            ts_r <= 1'b0;
        end else begin
            if (wr_mcr) begin
                pe_r <= mcr_w[`TSC_MCR_PE_BIT];
                mp_r <= mcr_w[`TSC_MCR_MP_BIT];
            end
            if (in_load) begin
                ts_r <= 1'b1;
            end else if (wr_mcr) begin
                ts_r <= mcr_w[`TSC_MCR_TS_BIT];
            end
        end
    end

    // flags and nested state
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            nt_r       <= 1'b0;
            nt_saved_r <= 1'b0;
            vm_r       <= 1'b0;
        end else if (in_load) begin
            vm_r <= dattr_r[`TSC_ATTR_VM_BIT];
            nt_r <= nests | dattr_r[`TSC_ATTR_NT_BIT];
        end else if (in_check && !chk_fault && !any_switch) begin
            if (cmd_r == CMD_INT) begin
                nt_saved_r <= nt_r;
                nt_r       <= 1'b0;
            end else if (cmd_r == CMD_INTERRUPT_RETURN) begin
                nt_r <= nt_saved_r;
            end else if (cmd_r == CMD_FLAG_POP_INSTR) begin
                nt_r <= flag_pop_instr_nt_r;
            end
        end
    end

    // task pointer and switch bookkeeping
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            tr_sel_r     <= 16'h0000;
            tr_base_r    <= `TSC_RST_WORD;
            tr_limit_r   <= `TSC_RST_WORD;
            busy_type_r  <= 4'h0;
            link_sel_r   <= 16'h0000;
            switch_cnt_r <= 8'h00;
        end else if (in_load) begin
            tr_sel_r     <= tgt_sel;
            tr_base_r    <= dbase_r;
            tr_limit_r   <= dlimit_r;
            busy_type_r  <= interrupt_return_switch ? tgt_type : busy_type;
            link_sel_r   <= nests ? tr_sel_r : 16'h0000;
            switch_cnt_r <= switch_cnt_r + 8'h01;
        end
    end

    // exception reporting, output pulses and registered mode outputs
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            exc_vec_r        <= 8'h00;
            exc_valid_r      <= 1'b0;
            exception_o      <= 1'b0;
            exception_vec_o  <= 8'h00;
            switch_save_o    <= 1'b0;
            switch_load_o    <= 1'b0;
            tlb_flush_o      <= 1'b0;
            protected_mode_o <= 1'b0;
            virtual_mode_o   <= 1'b0;
        end else begin
            exception_o      <= 1'b0;
            switch_save_o    <= state_r == ST_SAVE;
            switch_load_o    <= in_load;
            tlb_flush_o      <= flush_now;
            protected_mode_o <= pe_r;
            virtual_mode_o   <= vm_r;
            if (start) begin
                exc_valid_r <= 1'b0;
            end
            if (in_check && chk_fault) begin
                exc_vec_r       <= chk_vec;
                exc_valid_r     <= 1'b1;
                exception_o     <= 1'b1;
                exception_vec_o <= chk_vec;
            end else if (in_load && dattr_r[`TSC_ATTR_T_BIT]) begin
                exc_vec_r       <= `TSC_VEC_DEBUG;
                exc_valid_r     <= 1'b1;
                exception_o     <= 1'b1;
                exception_vec_o <= `TSC_VEC_DEBUG;
            end
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_busy_fault;
        in_check && fault_busy |=> exception_o && exception_vec_o == 8'h0D ##1 state_r == ST_IDLE;
    endproperty
    a_busy_fault: assert property (p_busy_fault) else $error("busy target not faulted");

    property p_ts_set;
        in_load |=> ts_r && tlb_flush_o == !$past(ts_r);
    endproperty
    a_ts_set: assert property (p_ts_set) else $error("switch did not set flag");

    property p_esc_trap;
        in_check && cmd_r == CMD_ESC && ts_r |=> exception_o && exception_vec_o == 8'h07;
    endproperty
    a_esc_trap: assert property (p_esc_trap) else $error("escape not trapped");

    property p_wait_trap;
        in_check && cmd_r == CMD_WAIT |=> exception_o == ($past(ts_r) && $past(mp_r));
    endproperty
    a_wait_trap: assert property (p_wait_trap) else $error("wait trap wrong");

    property p_call_nest;
        in_load && nests |=> nt_r && link_sel_r == $past(tr_sel_r);
    endproperty
    a_call_nest: assert property (p_call_nest) else $error("nesting not recorded");

    property p_int_clear;
        in_check && cmd_r == CMD_INT && !named_gate |=> !nt_r && nt_saved_r == $past(nt_r);
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("nested flag not cleared");

    property p_pdbr_flush;
        wr_pdbr |=> tlb_flush_o && pdbr_r == $past(pdbr_w[31:12]);
    endproperty
    a_pdbr_flush: assert property (p_pdbr_flush) else $error("no flush on page base");

    property p_pdbr_low;
        avs_read_i && take && avs_address_i == `TSC_OFF_PDBR |=> avs_readdata_o[11:0] == 12'h000;
    endproperty
    a_pdbr_low: assert property (p_pdbr_low) else $error("page base low bits set");

    property p_tr_load;
        in_load |=> tr_base_r == $past(dbase_r) && tr_limit_r == $past(dlimit_r);
    endproperty
    a_tr_load: assert property (p_tr_load) else $error("hidden base not loaded");

    property p_interrupt_return_switch;
        in_check && interrupt_return_switch && !chk_fault |=> state_r == ST_SAVE ##1 switch_save_o ##1
            tr_sel_r == $past(dattr_r[31:16], 2);
    endproperty
    a_interrupt_return_switch: assert property (p_interrupt_return_switch) else $error("return switch wrong");

endmodule

`default_nettype wire

/* File: verif/tsc_desc_model.sv */
`timescale 1ns/1ps
`default_nettype none

// descriptor image handed to software for each selector
module tsc_desc_model
    import tsc_pkg::*;
(
    input  wire logic [15:0] sel_i,
    output logic      [31:0] base_o,
    output logic      [31:0] limit_o,
    output logic      [31:0] attr_o
);
    // tables built before protection is switched on
    assign base_o = {8'h00, sel_i, 8'h00};

    always_comb begin
        case (sel_i)
            16'h0010: limit_o = 32'h0000_0064;
            16'h0018: limit_o = 32'h0000_002B;
            16'h0020: limit_o = 32'h0000_002C;
            default:  limit_o = 32'h0000_0065;
        endcase
    end

    // gate entry: inner tss type 9, trap bit, virtual bit
    always_comb begin
        case (sel_i)
            16'h0018, 16'h0020: attr_o = 32'h0000_0001;
            16'h0028:           attr_o = 32'h0000_000B;
            16'h0030:           attr_o = 32'h0000_0395;
            default:            attr_o = 32'h0000_0009;
        endcase
    end
endmodule

`default_nettype wire

/* File: verif/tsc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tsc_consts.svh"

`define TSC_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end

module tsc_top_tb
    import tsc_pkg::*;
    ;
    logic        sys_clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [7:0]  avs_address_i = 8'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0]  avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        switch_save_o, switch_load_o, tlb_flush_o, exception_o;
    logic [7:0]  exception_vec_o;
    logic        protected_mode_o, virtual_mode_o;
    logic [15:0] msel = 16'h0000;
    logic [31:0] mbase, mlim, mattr, rdv;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          c_save = 0, c_load = 0, c_flush = 0, c_exc = 0;
    int          ds, dl, df, de;

    tsc_top tsc_top_i (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .switch_save_o(switch_save_o), .switch_load_o(switch_load_o),
        .tlb_flush_o(tlb_flush_o), .exception_o(exception_o),
        .exception_vec_o(exception_vec_o), .protected_mode_o(protected_mode_o),
        .virtual_mode_o(virtual_mode_o)
    );

    tsc_desc_model tsc_desc_model_i (
        .sel_i(msel), .base_o(mbase), .limit_o(mlim), .attr_o(mattr)
    );

    always #50 sys_clk_i = ~sys_clk_i;

    // pulse tally, sampled mid-cycle
    always @(negedge sys_clk_i) begin
        if (switch_save_o === 1'b1) c_save++;
        if (switch_load_o === 1'b1) c_load++;
        if (tlb_flush_o === 1'b1) c_flush++;
        if (exception_o === 1'b1) c_exc++;
    end

    task automatic summarize();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one avalon transfer, pulse deltas left in ds/dl/df/de
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int s0, l0, f0, e0;
        s0 = c_save;
        l0 = c_load;
        f0 = c_flush;
        e0 = c_exc;
        @(posedge sys_clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= !wr;
        // wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge sys_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        rdv = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        repeat (2) @(negedge sys_clk_i);
        @(posedge sys_clk_i);
        ds = c_save - s0;
        dl = c_load - l0;
        df = c_flush - f0;
        de = c_exc - e0;
    endtask

    task automatic chkrd(input logic [7:0] a, input logic [31:0] exp,
                         input logic [31:0] m = 32'hFFFF_FFFF);
        bus(1'b0, a, 32'h0000_0000);
        `TSC_CHK(rdv & m, exp)
    endtask

    task automatic cmd(input tsc_cmd_type c, input logic nt);
        bus(1'b1, `TSC_OFF_CMD, {17'h0_0000, nt, 10'h000, c});
    endtask

    // program target descriptor from the table image
    task automatic tgt(input logic [15:0] sel, input logic [31:0] extra);
        msel = sel;
        @(negedge sys_clk_i);
        bus(1'b1, `TSC_OFF_SEL, {16'h0000, sel});
        bus(1'b1, `TSC_OFF_DBASE, mbase);
        bus(1'b1, `TSC_OFF_DLIMIT, mlim);
        bus(1'b1, `TSC_OFF_DATTR, mattr | extra);
    endtask

    task automatic s_reset();
        `TSC_CHK(protected_mode_o, 1'b0)
        chkrd(`TSC_OFF_STATUS, 32'h0000_0000);
        chkrd(8'hFC, 32'h0000_0000);
    endtask

    task automatic s_protect();
        bus(1'b1, `TSC_OFF_MCR, 32'h0000_0001);
        `TSC_CHK(protected_mode_o, 1'b1)
        bus(1'b1, `TSC_OFF_PDBR, 32'h1234_5FFF);
        `TSC_CHK(df, 1)
        chkrd(`TSC_OFF_PDBR, 32'h1234_5000);
        tgt(16'h0008, 32'h0000_0000);
        cmd(CMD_JMP, 1'b0);
        `TSC_CHK(ds, 1)
        `TSC_CHK(dl, 1)
        `TSC_CHK(df, 1)
        chkrd(`TSC_OFF_TRSEL, 32'h0000_0008);
        chkrd(`TSC_OFF_TRBASE, 32'h0000_0800);
        chkrd(`TSC_OFF_TRLIM, 32'h0000_0065);
        chkrd(`TSC_OFF_RESULT, 32'h0000_B000, 32'hFFFF_F000);
        chkrd(`TSC_OFF_MCR, 32'h0000_0009);
    endtask

    task automatic s_call();
        bus(1'b1, `TSC_OFF_MCR, 32'h0000_0001);
        tgt(16'h0020, 32'h0000_0000);
        cmd(CMD_CALL, 1'b0);
        `TSC_CHK(df, 1)
        chkrd(`TSC_OFF_RESULT, 32'h0008_3000, 32'hFFFF_F000);
        chkrd(`TSC_OFF_FLAGS, 32'h0000_4000);
        chkrd(`TSC_OFF_MCR, 32'h0000_0009);
    endtask

    task automatic s_refuse();
        tgt(16'h0010, 32'h0000_0000);
        cmd(CMD_JMP, 1'b0);
        `TSC_CHK(ds, 0)
        `TSC_CHK(exception_vec_o, 8'h0A)
        tgt(16'h0018, 32'h0000_0000);
        cmd(CMD_JMP, 1'b0);
        `TSC_CHK(de, 1)
        `TSC_CHK(ds, 0)
        tgt(16'h0028, 32'h0000_0000);
        cmd(CMD_CALL, 1'b0);
        `TSC_CHK(ds, 0)
        `TSC_CHK(exception_vec_o, 8'h0D)
        chkrd(`TSC_OFF_TRSEL, 32'h0000_0020);
    endtask

    task automatic s_coproc();
        cmd(CMD_ESC, 1'b0);
        `TSC_CHK(exception_vec_o, 8'h07)
        bus(1'b1, `TSC_OFF_MCR, 32'h0000_0003);
        cmd(CMD_WAIT, 1'b0);
        `TSC_CHK(de, 0)
        bus(1'b1, `TSC_OFF_MCR, 32'h0000_000B);
        cmd(CMD_WAIT, 1'b0);
        `TSC_CHK(de, 1)
    endtask

    task automatic s_nested();
        cmd(CMD_FLAG_POP_INSTR, 1'b0);
        chkrd(`TSC_OFF_FLAGS, 32'h0000_0000, 32'h0000_4000);
        cmd(CMD_FLAG_POP_INSTR, 1'b1);
        chkrd(`TSC_OFF_FLAGS, 32'h0000_4000, 32'h0000_4000);
        tgt(16'h0008, 32'h0000_0000);
        cmd(CMD_INT, 1'b0);
        `TSC_CHK(ds, 0)
        chkrd(`TSC_OFF_FLAGS, 32'h0000_0000, 32'h0000_4000);
        cmd(CMD_INTERRUPT_RETURN, 1'b0);
        `TSC_CHK(ds, 0)
        chkrd(`TSC_OFF_FLAGS, 32'h0000_4000, 32'h0000_4000);
        tgt(16'h0020, 32'h0018_0000);
        bus(1'b1, `TSC_OFF_SEL, 32'h0000_0077);
        cmd(CMD_INTERRUPT_RETURN, 1'b0);
        `TSC_CHK(ds, 1)
        `TSC_CHK(dl, 1)
        chkrd(`TSC_OFF_TRSEL, 32'h0000_0018);
    endtask

    task automatic s_gate();
        tgt(16'h0030, 32'h0000_0000);
        cmd(CMD_INT, 1'b0);
        `TSC_CHK(ds, 1)
        `TSC_CHK(exception_vec_o, 8'h01)
        `TSC_CHK(virtual_mode_o, 1'b1)
        chkrd(`TSC_OFF_FLAGS, 32'h0002_4000);
        cmd(CMD_FLAG_POP_INSTR, 1'b0);
        chkrd(`TSC_OFF_FLAGS, 32'h0002_0000, 32'h0002_0000);
        tgt(16'h0008, 32'h0000_0000);
        cmd(CMD_JMP, 1'b0);
        `TSC_CHK(virtual_mode_o, 1'b0)
        chkrd(`TSC_OFF_STATUS, 32'h0000_0505, 32'h0000_FF07);
    endtask

    initial begin
        repeat (4) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        s_reset();
        s_protect();
        s_call();
        s_refuse();
        s_coproc();
        s_nested();
        s_gate();
        summarize();
    end

    // hang guard, well beyond the 78 transfers above
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_mismatch++;
        summarize();
    end
endmodule

`default_nettype wire
